// ==== sfs_pkg.sv ====
/*
 * sfs_pkg: constants, state codes and bundles for the secondary fault
 * status block. Assumes a single 100 MHz ref_clk domain and a 32-bit
 * AHB-Lite register bus with byte addresses.
 */
`default_nettype none

package sfs_pkg;

   // register byte offsets
   localparam logic [7:0] SFS_STATUS_OFS   = 8'h00;
   localparam logic [7:0] SFS_IRQ_STAT_OFS = 8'h04;
   localparam logic [7:0] SFS_IRQ_MASK_OFS = 8'h08;
   localparam logic [7:0] SFS_ROUTE_OFS    = 8'h0c;
   localparam logic [7:0] SFS_STATE_OFS    = 8'h10;

   // status field positions
   localparam int SFS_ALARM_OR_BIT = 10;
   localparam int SFS_WARN_OR_BIT  = 9;
   localparam int SFS_SELFTEST_BIT = 8;
   localparam int SFS_CLKMON_BIT   = 7;
   localparam int SFS_CFGCRC_BIT   = 6;
   localparam int SFS_TRIMCRC_BIT  = 5;

   // routing register: low nibble to alarm pin, high nibble to warning pin
   localparam int SFS_ROUTE_ALARM_LSB = 0;
   localparam int SFS_ROUTE_WARN_LSB  = 4;

   // values after reset, checksum seed and polynomial
   localparam logic [15:0] SFS_STATUS_RST   = 16'h0000;
   localparam logic [15:0] SFS_IRQ_MASK_RST = 16'h0000;
   localparam logic [7:0]  SFS_ROUTE_RST    = 8'h0f;
   localparam logic [15:0] SFS_CRC_SEED     = 16'hffff;
   localparam logic [15:0] SFS_CRC_POLY     = 16'h1021;

   // primary clock period window, in ns, and derived ref_clk counts
   localparam int SFS_REF_CLK_MHZ   = 100;
   localparam int SFS_PRI_MIN_NS    = 60;
   localparam int SFS_PRI_MAX_NS    = 100;
   localparam int SFS_PRI_MIN_CYC   = (SFS_PRI_MIN_NS * SFS_REF_CLK_MHZ + 999) / 1000;
   localparam int SFS_PRI_MAX_CYC   = (SFS_PRI_MAX_NS * SFS_REF_CLK_MHZ) / 1000;
   localparam int SFS_MON_CNT_W     = 8;

   // width of the vector that the checksum function folds
   localparam int SFS_CRC_IN_W = 128;

   // device operating state, supplied by the device sequencer
   typedef enum logic [1:0] {
      SFS_ST_POWERUP = 2'b00,
      SFS_ST_CONFIG1 = 2'b01,
      SFS_ST_CONFIG2 = 2'b10,
      SFS_ST_ACTIVE  = 2'b11
   } sfs_opstate_t;

   // clock monitor states
   typedef enum logic [0:0] {
      SFS_MON_WAIT = 1'b0,
      SFS_MON_RUN  = 1'b1
   } sfs_monstate_t;

   // latched fault flags, msb first in status bit order
   typedef struct packed {
      logic selftestFaultFlag;
      logic clockMismatchFlag;
      logic configCrcFaultFlag;
      logic trimCrcFaultFlag;
   } sfs_faults_t;

   // write strobes decoded by the serial host port during configuration
   typedef struct packed {
      logic serialTestRegWrite;
      logic reservedBitWrite;
   } sfs_cfgwr_t;

endpackage : sfs_pkg

`default_nettype wire

// ==== sfs_fault_status.sv ====
/*
 * sfs_fault_status: secondary side fault status bits with checksum
 * watchdogs on configuration and trim storage, a primary clock monitor,
 * fault pin summaries, an interrupt status/mask pair and an AHB-Lite
 * slave. Assumes opState, the config and trim words and the write
 * strobes come from logic on ref_clk; the primary clock is a pin.
 */
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`default_nettype none

module sfs_fault_status
   import sfs_pkg::*;
#(
   parameter int CFG_REGS = 8,
   parameter int CFG_W    = 16,
   parameter int TRIM_W   = 64
) (
   input  wire logic                      ref_clk,
   input  wire logic                      srst,
   // ahb-lite slave
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic                           hreadyout,
   output logic                           hresp,
   output logic [31:0]                    hrdata,
   // device context
   input  wire sfs_opstate_t              opState,
   input  wire logic                      selftestDone,
   input  wire logic                      selftestFail,
   input  wire logic                      primaryClkPin,
   input  wire logic [CFG_REGS*CFG_W-1:0] configWords,
   input  wire sfs_cfgwr_t                configWrites,
   input  wire logic [TRIM_W-1:0]         trimBits,
   // outputs
   output logic                           alarmFaultPinN,
   output logic                           warningFaultPinN,
   output logic                           irq
);

   // checksum over a zero-padded vector, shared by config and trim
   function automatic logic [15:0] crcFold(input logic [SFS_CRC_IN_W-1:0] vec);
      logic [15:0] c;
      c = SFS_CRC_SEED;
      for (int i = SFS_CRC_IN_W - 1; i >= 0; i--) begin
         c = (c[15] ^ vec[i]) ? ((c << 1) ^ SFS_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crcFold

   logic [15:0]     cfgCrc;
   logic [15:0]     trimCrc;
   logic [15:0]     cfgSnap_q;
   logic [15:0]     trimSnap_q;
   sfs_opstate_t    prevState_q;
   logic            trimWatch;
   logic            selftestSeen_q;
   sfs_faults_t     faults_q;
   sfs_faults_t     faults_d;
   logic [3:0]      faultVec;
   logic            alarmOr_q;
   logic            warnOr_q;
   logic [15:0]     statusWord;
   logic [15:0]     irqStat_q;
   logic [15:0]     irqMask_q;
   logic [15:0]     irqEvent;
   logic [15:0]     irqClear;
   logic [7:0]      route_q;
   logic            addrPhase;
   logic            wrPend_q;
   logic [7:0]      wrAddr_q;
   logic [31:0]     rdData_q;
   logic            priSync1_q;
   logic            priSync2_q;
   logic            priLast_q;
   logic            priRise;
   sfs_monstate_t   monState_q;
   logic [SFS_MON_CNT_W-1:0] monCnt_q;
   logic            monBad;

   // both checksums are recomputed every cycle from the live storage
   assign cfgCrc  = crcFold(SFS_CRC_IN_W'(configWords));
   assign trimCrc = crcFold(SFS_CRC_IN_W'(trimBits));

   // trim storage is only watched in the two later states
   assign trimWatch = (opState == SFS_ST_CONFIG2) || (opState == SFS_ST_ACTIVE);

   // state history, used to skip the config checksum compare on the first active cycle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prevState_q <= SFS_ST_POWERUP;
      end else begin
         prevState_q <= opState;
      end
   end

   // config snapshot taken on the cycle before active begins counting
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cfgSnap_q <= SFS_CRC_SEED;
      end else if (opState != SFS_ST_ACTIVE) begin
         cfgSnap_q <= cfgCrc;
      end
   end

   // trim snapshot follows the storage while unwatched
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         trimSnap_q <= SFS_CRC_SEED;
      end else if (!trimWatch) begin
         trimSnap_q <= trimCrc;
      end
   end

   // primary clock pin synchroniser, second stage feeds the edge detect;
   // all stages reset high so a pin parked at either level shows no false rise
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         priSync1_q <= 1'b1;
         priSync2_q <= 1'b1;
         priLast_q  <= 1'b1;
      end else begin
         priSync1_q <= primaryClkPin;
         priSync2_q <= priSync1_q;
         priLast_q  <= priSync2_q;
      end
   end

   assign priRise = priSync2_q & ~priLast_q;

   // period too short, too long, or clock stuck past the max window
   assign monBad = (monState_q == SFS_MON_RUN) &&
                   ((priRise && (monCnt_q < SFS_MON_CNT_W'(SFS_PRI_MIN_CYC))) ||
                    (monCnt_q > SFS_MON_CNT_W'(SFS_PRI_MAX_CYC)));

   // clock monitor: arms on the first primary edge, then times each period
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         monState_q <= SFS_MON_WAIT;
         monCnt_q   <= '0;
      end else begin
         case (monState_q)
            SFS_MON_WAIT: begin
               monCnt_q <= '0;
               if (priRise) begin
                  monState_q <= SFS_MON_RUN;
               end
            end
            SFS_MON_RUN: begin
               if (priRise) begin
                  monCnt_q <= SFS_MON_CNT_W'(1);
               end else if (monCnt_q != '1) begin
                  monCnt_q <= monCnt_q + SFS_MON_CNT_W'(1); // saturates
               end
            end
            default: begin
               monState_q <= SFS_MON_WAIT;
               monCnt_q   <= '0;
            end
         endcase
      end
   end

   // self-test result only counts for the first report made while in power-up
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         selftestSeen_q <= 1'b0;
      end else if (selftestDone && opState == SFS_ST_POWERUP) begin
         selftestSeen_q <= 1'b1;
      end
   end

   // fault flags are sticky; nothing but reset clears them
   always_comb begin
      faults_d = faults_q;
      if (selftestDone && selftestFail && !selftestSeen_q &&
          opState == SFS_ST_POWERUP) begin
         faults_d.selftestFaultFlag = 1'b1;
      end
      if (monBad) begin
         faults_d.clockMismatchFlag = 1'b1;
      end
      if (opState == SFS_ST_ACTIVE && prevState_q == SFS_ST_ACTIVE &&
          cfgCrc != cfgSnap_q) begin
         faults_d.configCrcFaultFlag = 1'b1;
      end
      if (opState == SFS_ST_CONFIG2 && (configWrites.serialTestRegWrite ||
                                        configWrites.reservedBitWrite)) begin
         faults_d.configCrcFaultFlag = 1'b1;
      end
      if (trimWatch && trimCrc != trimSnap_q) begin
         faults_d.trimCrcFaultFlag = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         faults_q <= '0;
      end else begin
         faults_q <= faults_d;
      end
   end

   assign faultVec = faults_q;

   // pin summaries, registered so the pins never glitch
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         alarmOr_q <= 1'b0;
         warnOr_q  <= 1'b0;
      end else begin
         alarmOr_q <= |(faultVec & route_q[SFS_ROUTE_ALARM_LSB +: 4]);
         warnOr_q  <= |(faultVec & route_q[SFS_ROUTE_WARN_LSB +: 4]);
      end
   end

   assign alarmFaultPinN   = ~alarmOr_q;
   assign warningFaultPinN = ~warnOr_q;

   // status word, reserved bits read zero
   always_comb begin
      statusWord = SFS_STATUS_RST;
      statusWord[SFS_ALARM_OR_BIT] = alarmOr_q;
      statusWord[SFS_WARN_OR_BIT]  = warnOr_q;
      statusWord[SFS_SELFTEST_BIT] = faults_q.selftestFaultFlag;
      statusWord[SFS_CLKMON_BIT]   = faults_q.clockMismatchFlag;
      statusWord[SFS_CFGCRC_BIT]   = faults_q.configCrcFaultFlag;
      statusWord[SFS_TRIMCRC_BIT]  = faults_q.trimCrcFaultFlag;
   end

   // interrupt events are the rising edges of the fault flags
   always_comb begin
      irqEvent = '0;
      irqEvent[SFS_SELFTEST_BIT] = faults_d.selftestFaultFlag  & ~faults_q.selftestFaultFlag;
      irqEvent[SFS_CLKMON_BIT]   = faults_d.clockMismatchFlag  & ~faults_q.clockMismatchFlag;
      irqEvent[SFS_CFGCRC_BIT]   = faults_d.configCrcFaultFlag & ~faults_q.configCrcFaultFlag;
      irqEvent[SFS_TRIMCRC_BIT]  = faults_d.trimCrcFaultFlag   & ~faults_q.trimCrcFaultFlag;
   end

   // ahb address phase accepted; zero wait states, always okay
   assign addrPhase = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdData_q;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= '0;
      end else begin
         wrPend_q <= addrPhase && hwrite;
         wrAddr_q <= haddr[7:0];
      end
   end

   // write-one-to-clear mask, applied in the data phase
   assign irqClear = (wrPend_q && wrAddr_q == SFS_IRQ_STAT_OFS) ? hwdata[15:0] : '0;

   // a new event wins over a clear landing in the same cycle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irqStat_q <= '0;
      end else begin
         irqStat_q <= (irqStat_q & ~irqClear) | irqEvent;
      end
   end

   // writable mask and routing; the status word takes no writes
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irqMask_q <= SFS_IRQ_MASK_RST;
         route_q   <= SFS_ROUTE_RST;
      end else if (wrPend_q) begin
         if (wrAddr_q == SFS_IRQ_MASK_OFS) begin
            irqMask_q <= hwdata[15:0];
         end
         if (wrAddr_q == SFS_ROUTE_OFS) begin
            route_q <= hwdata[7:0];
         end
      end
   end

   // read data captured at the address phase, held until the next read
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdData_q <= '0;
      end else if (addrPhase && !hwrite) begin
         case (haddr[7:0])
            SFS_STATUS_OFS:   rdData_q <= {16'h0000, statusWord};
            SFS_IRQ_STAT_OFS: rdData_q <= {16'h0000, irqStat_q};
            SFS_IRQ_MASK_OFS: rdData_q <= {16'h0000, irqMask_q};
            SFS_ROUTE_OFS:    rdData_q <= {24'h000000, route_q};
            SFS_STATE_OFS:    rdData_q <= {29'h00000000, monState_q, opState};
            default:          rdData_q <= 32'h00000000;
         endcase
      end
   end

   // level interrupt, registered
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irqStat_q & ~irqClear | irqEvent) & irqMask_q);
      end
   end

endmodule : sfs_fault_status

`default_nettype wire

// ==== sfs_fault_status_props.sv ====
/*
 * sfs_fault_status_props: port-level checks for the secondary fault
 * status block. Assumes one ref_clk domain, srst synchronous active
 * high, and the bus hready looped back from hreadyout.
 */
`default_nettype none

module sfs_fault_status_props
   import sfs_pkg::*;
#(
   parameter int CFG_REGS = 8,
   parameter int CFG_W    = 16,
   parameter int TRIM_W   = 64
) (
   input wire logic                      ref_clk,
   input wire logic                      srst,
   input wire logic                      hsel,
   input wire logic [31:0]               haddr,
   input wire logic [1:0]                htrans,
   input wire logic                      hwrite,
   input wire logic [31:0]               hwdata,
   input wire logic                      hready,
   input wire logic [31:0]               hrdata,
   input wire sfs_opstate_t              opState,
   input wire logic                      selftestDone,
   input wire logic                      selftestFail,
   input wire logic [CFG_REGS*CFG_W-1:0] configWords,
   input wire sfs_cfgwr_t                configWrites,
   input wire logic [TRIM_W-1:0]         trimBits,
   input wire logic                      alarmFaultPinN,
   input wire logic                      warningFaultPinN,
   input wire logic                      irq
);
   logic       wrRoute_q;
   logic [7:0] route_q;
   logic       doneSeen_q;

   // shadow of the routing register, so pin checks know where faults go
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wrRoute_q <= 1'b0;
         route_q   <= SFS_ROUTE_RST;
      end else begin
         wrRoute_q <= hsel && htrans[1] && hready && hwrite && (haddr[7:0] == SFS_ROUTE_OFS);
         if (wrRoute_q && hready) begin
            route_q <= hwdata[7:0];
         end
      end
   end

   // only the first self-test result after reset counts
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         doneSeen_q <= 1'b0;
      end else if (selftestDone) begin
         doneSeen_q <= 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   property p_rst_quiet;
      disable iff (1'b0) srst |=> !irq && alarmFaultPinN && warningFaultPinN && hrdata == 32'h0;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");
   property p_rd_hold;
      !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
   property p_cfg_active;
      (opState == SFS_ST_ACTIVE) [*3] ##0 ($changed(configWords) && route_q[1])
         |-> ##[1:3] !alarmFaultPinN;
   endproperty
   a_cfg_active: assert property (p_cfg_active) else $error("config change missed");
   property p_cfg_write;
      opState == SFS_ST_CONFIG2 && (|configWrites) && route_q[1] |-> ##[1:3] !alarmFaultPinN;
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config strobe missed");
   property p_trim;
      (opState == SFS_ST_CONFIG2) [*2] ##0 ($changed(trimBits) && route_q[0])
         |-> ##[1:3] !alarmFaultPinN;
   endproperty
   a_trim: assert property (p_trim) else $error("trim change missed");
   property p_selftest;
      opState == SFS_ST_POWERUP && selftestDone && selftestFail && !doneSeen_q && route_q[3]
         |-> ##[1:3] !alarmFaultPinN;
   endproperty
   a_selftest: assert property (p_selftest) else $error("self-test fail missed");
   property p_alarm_route;
      (route_q[3:0] == 4'h0) [*3] |-> alarmFaultPinN;
   endproperty
   a_alarm_route: assert property (p_alarm_route) else $error("alarm pin without route");
   property p_warn_route;
      (route_q[7:4] == 4'h0) [*3] |-> warningFaultPinN;
   endproperty
   a_warn_route: assert property (p_warn_route) else $error("warning pin without route");

endmodule : sfs_fault_status_props

bind sfs_fault_status sfs_fault_status_props #(
   .CFG_REGS(CFG_REGS), .CFG_W(CFG_W), .TRIM_W(TRIM_W)
) sfs_fault_status_props_inst (
   .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .opState(opState),
   .selftestDone(selftestDone), .selftestFail(selftestFail), .configWords(configWords),
   .configWrites(configWrites), .trimBits(trimBits), .alarmFaultPinN(alarmFaultPinN),
   .warningFaultPinN(warningFaultPinN), .irq(irq)
);

`default_nettype wire

// ==== sfs_fault_status_test.sv ====
/*
 * sfs_fault_status_test: self-checking bench for the fault status block.
 * Assumes a single slave on the bus, so hready is taken from hreadyout.
 */
`default_nettype none

module sfs_fault_status_test
   import sfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic         ref_clk, srst, hsel, hwrite, hreadyout, hresp, rdPhase, clkRun;
   logic [31:0]  haddr, hwdata, hrdata;
   logic [1:0]   htrans;
   logic [2:0]   hsize;
   sfs_opstate_t opState;
   logic         selftestDone, selftestFail, primaryClkPin, alarmFaultPinN;
   logic         warningFaultPinN, irq;
   logic [127:0] configWords;
   sfs_cfgwr_t   configWrites;
   logic [63:0]  trimBits;
   logic [31:0]  expQ[$];
   logic [31:0]  pinQ[$];
   int           priHalf = 4;
   int           num_errors, checks;

   sfs_fault_status sfs_fault_status_inst (
      .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .opState(opState),
      .selftestDone(selftestDone), .selftestFail(selftestFail),
      .primaryClkPin(primaryClkPin), .configWords(configWords),
      .configWrites(configWrites), .trimBits(trimBits), .alarmFaultPinN(alarmFaultPinN),
      .warningFaultPinN(warningFaultPinN), .irq(irq)
   );

   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   // primary clock, period 2*priHalf cycles, only while enabled
   initial begin
      primaryClkPin = 1'b0;
      forever begin
         repeat (priHalf) @(posedge ref_clk);
         if (clkRun) primaryClkPin <= ~primaryClkPin;
      end
   end

   task automatic final_report;
      $display("checks=%0d errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   task automatic cmp(input logic [31:0] act, input logic [31:0] exp);
      checks++;
      if (act !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
      end
   endtask : cmp

   // read data checked in its data phase against the oldest note
   always @(posedge ref_clk) begin
      if (rdPhase === 1'b1 && hreadyout === 1'b1) cmp(hrdata, expQ.pop_front());
   end

   task automatic cmpPins(input logic [31:0] act, input logic [31:0] exp);
      checks++;
      if (act !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t pins got=%h exp=%h", $time, act, exp);
      end
   endtask : cmpPins

   // pin notes checked at the falling edge, where registered pins have settled;
   // hresp rides along at bit 3 and must always read okay
   always @(negedge ref_clk) begin
      if (pinQ.size() > 0) cmpPins({28'h0, hresp, irq, alarmFaultPinN, warningFaultPinN},
                                   pinQ.pop_front());
   end

   task automatic pins(input logic [31:0] e);
      pinQ.push_back(e);
   endtask : pins

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   // bounded wait for hready at a rising edge
   task automatic waitReady;
      int n;
      n = 0;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            num_errors++;
            final_report();
         end
         @(posedge ref_clk);
      end
   endtask : waitReady

   // one single transfer; for a read, d is the expected word
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      waitReady();
      if (!wr) expQ.push_back(d);
      hsel    <= 1'b0;
      htrans  <= 2'b00;
      hwdata  <= d;
      rdPhase <= !wr;
      waitReady();
      rdPhase <= 1'b0;
   endtask : bus

   task automatic rst;
      srst         <= 1'b1;
      opState      <= SFS_ST_POWERUP;
      configWrites <= '0;
      selftestDone <= 1'b0;
      tick(4);
      srst <= 1'b0;
      tick(1);
   endtask : rst

   task automatic setState(input sfs_opstate_t s);
      opState <= s;
      tick(3);
   endtask : setState

   task automatic strobe(input sfs_cfgwr_t w);
      configWrites <= w;
      tick(1);
      configWrites <= '0;
      tick(4);
   endtask : strobe

   initial begin
      void'($urandom(81113));
      {hsel, hwrite, rdPhase, clkRun, selftestFail} = '0;
      {haddr, hwdata, htrans} = '0;
      hsize       = 3'h2;
      configWords = {$urandom(), $urandom(), $urandom(), $urandom()};
      trimBits    = {$urandom(), $urandom()};
      rst();
      // reset values, read-only status, unmapped space
      bus(1'b0, SFS_STATUS_OFS, 32'h0);
      bus(1'b1, SFS_STATUS_OFS, 32'hffff);
      bus(1'b0, SFS_STATUS_OFS, 32'h0);
      bus(1'b0, SFS_ROUTE_OFS, {24'h0, SFS_ROUTE_RST});
      bus(1'b0, 8'h40, 32'h0);
      pins(32'h3);
      $display("test reset done");
      // trim unwatched in config1, watched in config2, then irq mask and clear
      setState(SFS_ST_CONFIG1);
      trimBits <= ~trimBits;
      tick(4);
      bus(1'b0, SFS_STATUS_OFS, 32'h0);
      setState(SFS_ST_CONFIG2);
      trimBits <= trimBits ^ (64'h1 << $urandom_range(63, 0));
      tick(4);
      bus(1'b0, SFS_STATUS_OFS, 32'h420);
      pins(32'h1);
      bus(1'b1, SFS_IRQ_MASK_OFS, 32'h20);
      tick(2);
      pins(32'h5);
      bus(1'b0, SFS_IRQ_STAT_OFS, 32'h20);
      bus(1'b1, SFS_IRQ_STAT_OFS, 32'h20);
      tick(2);
      pins(32'h1);
      bus(1'b0, SFS_IRQ_STAT_OFS, 32'h0);
      bus(1'b0, SFS_IRQ_MASK_OFS, 32'h20);
      $display("test trim done");
      // both config strobes, first one routed to the warning pin
      for (int i = 0; i < 2; i++) begin
         rst();
         if (i == 0) bus(1'b1, SFS_ROUTE_OFS, 32'hf0);
         setState(SFS_ST_CONFIG1);
         strobe(i == 0 ? 2'b10 : 2'b01);
         bus(1'b0, SFS_STATUS_OFS, 32'h0);
         setState(SFS_ST_CONFIG2);
         strobe(i == 0 ? 2'b10 : 2'b01);
         bus(1'b0, SFS_STATUS_OFS, i == 0 ? 32'h240 : 32'h440);
         pins(i == 0 ? 32'h2 : 32'h1);
      end
      $display("test strobe done");
      // config edits count only while active
      rst();
      setState(SFS_ST_CONFIG2);
      configWords <= ~configWords;
      tick(4);
      bus(1'b0, SFS_STATUS_OFS, 32'h0);
      setState(SFS_ST_ACTIVE);
      configWords <= configWords ^ (128'h1 << $urandom_range(127, 0));
      tick(4);
      bus(1'b0, SFS_STATUS_OFS, 32'h440);
      $display("test config done");
      // self-test fail counts only at power-up
      for (int i = 0; i < 2; i++) begin
         rst();
         if (i == 0) setState(SFS_ST_ACTIVE);
         selftestFail <= 1'b1;
         selftestDone <= 1'b1;
         tick(1);
         selftestDone <= 1'b0;
         tick(4);
         bus(1'b0, SFS_STATUS_OFS, i == 0 ? 32'h0 : 32'h500);
      end
      $display("test selftest done");
      // good primary clock, then stuck
      rst();
      clkRun <= 1'b1;
      tick(40);
      bus(1'b0, SFS_STATUS_OFS, 32'h0);
      bus(1'b0, SFS_STATE_OFS, 32'h4);
      clkRun <= 1'b0;
      tick(20);
      bus(1'b0, SFS_STATUS_OFS, 32'h480);
      // too fast a primary clock; the pin may sit high across this reset
      rst();
      priHalf = 2;
      clkRun <= 1'b1;
      tick(20);
      bus(1'b0, SFS_STATUS_OFS, 32'h480);
      $display("test clock done");
      tick(2);
      final_report();
   end

endmodule : sfs_fault_status_test

`default_nettype wire
